// File: srl_pkg.sv
package srl_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;
	localparam logic [3:0]  ADDR_DIV       = 4'h1;
	localparam logic [3:0]  ADDR_TXBUF     = 4'h2;
	localparam logic [3:0]  ADDR_RXBUF     = 4'h3;
	localparam logic [3:0]  ADDR_STAT      = 4'h4;

	// ==========================================================
	// Control field positions
	localparam int          CTRL_TX_EN     = 0;
	localparam int          CTRL_RX_EN     = 1;
	localparam int          CTRL_ASYNC     = 2;
	localparam int          CTRL_CLK_EXT   = 3;
	localparam int          CTRL_TXIRQ_SEL = 4;
	localparam int          CTRL_CONT_RX   = 5;
	localparam int          CTRL_INVERT    = 6;
	localparam int          CTRL_MSB_FIRST = 7;
	localparam int          CTRL_LEN_LO    = 8;
	localparam int          CTRL_STOP2     = 10;
	localparam int          CTRL_PAR_EN    = 11;
	localparam int          CTRL_PAR_ODD   = 12;
	localparam int          CTRL_SRC_LO    = 13;
	localparam int          CTRL_OPEN_DRN  = 15;

	// ==========================================================
	// Status field positions
	localparam int          ST_TX_EMPTY    = 0;
	localparam int          ST_TX_IDLE     = 1;
	localparam int          ST_RX_FULL     = 2;
	localparam int          ST_OVERRUN     = 3;
	localparam int          ST_FRAMING     = 4;
	localparam int          ST_PARITY      = 5;
	localparam int          ST_ERR_SUM     = 6;

	// ==========================================================
	// Reset values and encodings
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [7:0]  DIV_RESET      = 8'h00;
	localparam logic [8:0]  TXBUF_RESET    = 9'h000;
	localparam logic [8:0]  DUMMY_DATA     = 9'h1ff;
	localparam logic [1:0]  LEN_7          = 2'h0;
	localparam logic [1:0]  LEN_8          = 2'h1;
	localparam logic [1:0]  SRC_F1         = 2'h0;
	localparam logic [1:0]  SRC_F8         = 2'h1;

	// ==========================================================
	// Timing counts
	localparam logic [4:0]  PRE_LAST8      = 5'h07;
	localparam logic [4:0]  PRE_LAST32     = 5'h1f;
	localparam logic [3:0]  LAST_TICK      = 4'hf;
	localparam logic [3:0]  MID_TICK       = 4'h7;
	localparam logic [3:0]  RISE_TICK      = 4'h8;
	localparam logic [3:0]  SYNC_BITS      = 4'h8;

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
	} srl_tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
	} srl_rx_state_t;

endpackage

// File: srl_baud_if.sv
`timescale 1ns/1ps
interface srl_baud_if;
	logic [1:0] src;
	logic       ext_sel;
	logic [7:0] div;
	logic       ext_edge;
	logic       tick;

	modport gen  (input src, input ext_sel, input div, input ext_edge,
	              output tick);
	modport user (output src, output ext_sel, output div, output ext_edge,
	              input tick);
endinterface

// File: srl_baud.sv
`timescale 1ns/1ps
module srl_baud (
	input wire logic clk,
	input wire logic nrst,
	srl_baud_if.gen  bif
);
	logic [4:0] pre;
	logic [7:0] cnt;
	logic       src_tick;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre <= 5'h00;
		end else begin
			pre <= pre + 5'h01;
		end
	end

	// Source pick: f1, f8, f32 or external clock edge
	always_comb begin
		if (bif.ext_sel) begin
			src_tick = bif.ext_edge;
		end else if (bif.src == srl_pkg::SRC_F1) begin
			src_tick = 1'b1;
		end else if (bif.src == srl_pkg::SRC_F8) begin
			src_tick = (pre[2:0] == srl_pkg::PRE_LAST8[2:0]);
		end else begin
			src_tick = (pre == srl_pkg::PRE_LAST32);
		end
	end

	// Divide by n+1 to give the sixteen-times clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt      <= 8'h00;
			bif.tick <= 1'b0;
		end else if (src_tick) begin
			bif.tick <= (cnt >= bif.div);
			cnt      <= (cnt >= bif.div) ? 8'h00 : cnt + 8'h01;
		end else begin
			bif.tick <= 1'b0;
		end
	end
endmodule

// File: srl_uart.sv
// Summary of operation
// - Synchronous mode shifts LSB first when order bit is 0, MSB first otherwise.
// - With continuous receive, reading the receive buffer re-arms reception.
// - Invert control inverts data on transmit buffer write and receive buffer read.
// - Asynchronous character length is seven, eight or nine bits.
// - Frames have one start bit and one or two stop bits.
// - Odd, even or no parity is appended and checked.
// - Internal bit rate is chosen source clock over sixteen times divider plus one.
// - External bit rate is clock pin rate over sixteen times divider plus one.
// - Transmission starts only with transmit enabled and transmit buffer loaded, or in synchronous continuous receive once re-armed.
// - Asynchronous reception starts only with receive enabled and a detected start bit.
// - Transmit request on buffer transfer, or on shift end when cause select is 1.
// - Receive request when a character moves into the receive buffer without an overrun.
// - Overrun flagged when a character arrives before the previous one was read.
// - Framing error when a configured stop bit is not seen high.
// - Parity error when ones count disagrees with the odd or even choice.
// - Error-sum flag is set by any overrun, framing or parity error.
// - Divider value is an eight-bit quantity from 0x00 to 0xff.
// - On overrun the buffer takes the new character and no receive request.
// - Transmit pin idles high, or floats when open-drain, until a transfer.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module srl_uart (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	output logic             serial_out_oe,
	input  wire logic        transfer_clock_pin_in,
	output logic             transfer_clock_pin_out,
	output logic             transfer_clock_pin_oe,
	output logic             tx_irq,
	output logic             rx_irq
);
	// ==========================================================
	// Declarations
	srl_pkg::srl_tx_state_t tx_state;
	srl_pkg::srl_rx_state_t rx_state;
	logic [15:0] ctrl;
	logic [7:0]  div;
	logic [8:0]  txbuf;
	logic        tx_empty;
	logic [8:0]  rxbuf;
	logic        rx_full;
	logic        overrun;
	logic        framing;
	logic        parity_err;
	logic        cont_armed;
	logic [2:0]  rx_sync;
	logic [2:0]  ck_sync;
	logic [8:0]  tx_shift;
	logic [3:0]  tx_cnt;
	logic [3:0]  tx_bits;
	logic [8:0]  rx_shift;
	logic        rx_par;
	logic        frame_bad;
	logic [3:0]  rx_cnt;
	logic [3:0]  rx_bits;
	logic        tick;
	logic        is_async;
	logic        par_en;
	logic [3:0]  len;
	logic [8:0]  mask;
	logic        tx_go;
	logic        tx_start;
	logic        tx_bit_end;
	logic        tx_done_ev;
	logic        rx_s;
	logic        rx_fall;
	logic        rx_samp;
	logic        async_done;
	logic        sync_done;
	logic        deliver;
	logic        fe_now;
	logic        pe_now;
	logic        rd_rx;
	logic        wr_stat;
	logic        ovr_set;
	logic        next_txd;
	logic        next_ck;

	srl_baud_if bif ();

	srl_baud u_baud (
		.clk  (clk),
		.nrst (nrst),
		.bif  (bif)
	);

	assign bif.src      = ctrl[srl_pkg::CTRL_SRC_LO +: 2];
	assign bif.ext_sel  = ctrl[srl_pkg::CTRL_CLK_EXT];
	assign bif.div      = div;
	assign bif.ext_edge = ck_sync[1] & ~ck_sync[2];
	assign tick         = bif.tick;

	function automatic logic [3:0] bit_idx(input logic       msb,
	                                       input logic [3:0] l,
	                                       input logic [3:0] n);
		bit_idx = msb ? 4'(l - 4'h1 - n) : n;
	endfunction

	// ==========================================================
	// Configuration decode
	assign is_async = ctrl[srl_pkg::CTRL_ASYNC];
	assign par_en   = ctrl[srl_pkg::CTRL_PAR_EN];
	assign rd_rx    = rd && (addr == srl_pkg::ADDR_RXBUF);
	assign wr_stat  = wr && (addr == srl_pkg::ADDR_STAT);

	always_comb begin
		if (!is_async) begin
			len  = srl_pkg::SYNC_BITS;
			mask = 9'h0ff;
		end else if (ctrl[srl_pkg::CTRL_LEN_LO +: 2] == srl_pkg::LEN_7) begin
			len  = 4'h7;
			mask = 9'h07f;
		end else if (ctrl[srl_pkg::CTRL_LEN_LO +: 2] == srl_pkg::LEN_8) begin
			len  = 4'h8;
			mask = 9'h0ff;
		end else begin
			len  = 4'h9;
			mask = 9'h1ff;
		end
	end

	// ==========================================================
	// Input synchronisers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_sync <= 3'h7;
			ck_sync <= 3'h7;
		end else begin
			rx_sync <= {rx_sync[1:0], serial_in_pin};
			ck_sync <= {ck_sync[1:0], transfer_clock_pin_in};
		end
	end

	assign rx_s    = rx_sync[1];
	assign rx_fall = rx_sync[2] & ~rx_sync[1];

	// ==========================================================
	// Register writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= srl_pkg::CTRL_RESET;
			div  <= srl_pkg::DIV_RESET;
		end else if (wr && addr == srl_pkg::ADDR_CTRL) begin
			ctrl <= wdata;
		end else if (wr && addr == srl_pkg::ADDR_DIV) begin
			div  <= wdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txbuf    <= srl_pkg::TXBUF_RESET;
			tx_empty <= 1'b1;
		end else if (wr && addr == srl_pkg::ADDR_TXBUF) begin
			txbuf    <= ctrl[srl_pkg::CTRL_INVERT] ? ~wdata[8:0]
			                                       : wdata[8:0];
			tx_empty <= 1'b0;
		end else if (tx_start) begin
			tx_empty <= 1'b1;
		end
	end

	// Continuous receive re-arm on buffer read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cont_armed <= 1'b0;
		end else if (rd_rx && ctrl[srl_pkg::CTRL_CONT_RX] && !is_async) begin
			cont_armed <= 1'b1;
		end else if (tx_start) begin
			cont_armed <= 1'b0;
		end
	end

	// ==========================================================
	// Transmitter
	assign tx_go = (ctrl[srl_pkg::CTRL_TX_EN] && !tx_empty) ||
	               (!is_async && cont_armed &&
	                ctrl[srl_pkg::CTRL_RX_EN]);
	assign tx_start   = (tx_state == srl_pkg::TX_IDLE) && tick && tx_go;
	assign tx_bit_end = tick && (tx_cnt == srl_pkg::LAST_TICK);
	assign tx_done_ev = tx_bit_end && (
		(tx_state == srl_pkg::TX_DATA && !is_async &&
		 tx_bits == 4'(len - 4'h1)) ||
		(tx_state == srl_pkg::TX_STOP &&
		 !(ctrl[srl_pkg::CTRL_STOP2] && tx_bits == 4'h0)));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_state <= srl_pkg::TX_IDLE;
			tx_bits  <= 4'h0;
			tx_shift <= 9'h000;
		end else begin
			unique case (tx_state)
				srl_pkg::TX_IDLE: begin
					if (tx_start) begin
						tx_shift <= tx_empty ? srl_pkg::DUMMY_DATA : txbuf;
						tx_bits  <= 4'h0;
						tx_state <= is_async ? srl_pkg::TX_START
						                     : srl_pkg::TX_DATA;
					end
				end
				srl_pkg::TX_START: begin
					if (tx_bit_end) begin
						tx_state <= srl_pkg::TX_DATA;
					end
				end
				srl_pkg::TX_DATA: begin
					if (tx_bit_end) begin
						if (tx_bits == 4'(len - 4'h1)) begin
							tx_bits  <= 4'h0;
							tx_state <= !is_async ? srl_pkg::TX_IDLE :
							            par_en    ? srl_pkg::TX_PARITY :
							                        srl_pkg::TX_STOP;
						end else begin
							tx_bits <= tx_bits + 4'h1;
						end
					end
				end
				srl_pkg::TX_PARITY: begin
					if (tx_bit_end) begin
						tx_state <= srl_pkg::TX_STOP;
					end
				end
				srl_pkg::TX_STOP: begin
					if (tx_bit_end) begin
						if (ctrl[srl_pkg::CTRL_STOP2] && tx_bits == 4'h0) begin
							tx_bits <= 4'h1;
						end else begin
							tx_state <= srl_pkg::TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_cnt <= 4'h0;
		end else if (tx_start) begin
			tx_cnt <= 4'h0;
		end else if (tick && tx_state != srl_pkg::TX_IDLE) begin
			tx_cnt <= tx_cnt + 4'h1;
		end
	end

	// Line level per state; idle stays high
	always_comb begin
		unique case (tx_state)
			srl_pkg::TX_START:  next_txd = 1'b0;
			srl_pkg::TX_DATA:   next_txd = tx_shift[bit_idx(
				ctrl[srl_pkg::CTRL_MSB_FIRST], len, tx_bits)];
			srl_pkg::TX_PARITY: next_txd = ^(tx_shift & mask) ^
			                               ctrl[srl_pkg::CTRL_PAR_ODD];
			default:            next_txd = 1'b1;
		endcase
		next_ck = !((tx_state == srl_pkg::TX_DATA) && !is_async &&
		            (tx_cnt < srl_pkg::RISE_TICK));
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			serial_out_pin         <= 1'b1;
			serial_out_oe          <= 1'b1;
			transfer_clock_pin_out <= 1'b1;
			transfer_clock_pin_oe  <= 1'b0;
		end else begin
			serial_out_pin         <= next_txd;
			serial_out_oe          <= !(ctrl[srl_pkg::CTRL_OPEN_DRN] &&
			                            next_txd);
			transfer_clock_pin_out <= next_ck;
			transfer_clock_pin_oe  <= !is_async &&
			                          !ctrl[srl_pkg::CTRL_CLK_EXT];
		end
	end

	// ==========================================================
	// Receiver
	assign rx_samp    = tick && (rx_cnt == srl_pkg::LAST_TICK);
	assign async_done = (rx_state == srl_pkg::RX_STOP) && rx_samp &&
	                    !(ctrl[srl_pkg::CTRL_STOP2] && rx_bits == 4'h0);
	assign sync_done  = tx_done_ev && !is_async &&
	                    ctrl[srl_pkg::CTRL_RX_EN];
	assign deliver    = async_done || sync_done;
	assign fe_now     = async_done && (frame_bad || !rx_s);
	assign pe_now     = async_done && par_en &&
	                    ((^(rx_shift & mask) ^ rx_par) !=
	                     ctrl[srl_pkg::CTRL_PAR_ODD]);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_state  <= srl_pkg::RX_IDLE;
			rx_cnt    <= 4'h0;
			rx_bits   <= 4'h0;
			rx_shift  <= 9'h000;
			rx_par    <= 1'b0;
			frame_bad <= 1'b0;
		end else begin
			if (tick && rx_state != srl_pkg::RX_IDLE) begin
				rx_cnt <= rx_cnt + 4'h1;
			end
			if (tx_start && !is_async) begin
				rx_shift <= 9'h000;
			end else if (tx_state == srl_pkg::TX_DATA && !is_async &&
			             tick && tx_cnt == srl_pkg::RISE_TICK) begin
				rx_shift[bit_idx(ctrl[srl_pkg::CTRL_MSB_FIRST], len,
				                 tx_bits)] <= rx_s;
			end
			unique case (rx_state)
				srl_pkg::RX_IDLE: begin
					if (is_async && ctrl[srl_pkg::CTRL_RX_EN] && rx_fall) begin
						rx_state  <= srl_pkg::RX_START;
						rx_cnt    <= 4'h0;
						frame_bad <= 1'b0;
					end
				end
				srl_pkg::RX_START: begin
					if (tick && rx_cnt == srl_pkg::MID_TICK) begin
						rx_cnt   <= 4'h0;
						rx_bits  <= 4'h0;
						rx_shift <= 9'h000;
						rx_state <= rx_s ? srl_pkg::RX_IDLE
						                 : srl_pkg::RX_DATA;
					end
				end
				srl_pkg::RX_DATA: begin
					if (rx_samp) begin
						rx_shift[bit_idx(ctrl[srl_pkg::CTRL_MSB_FIRST], len,
						                 rx_bits)] <= rx_s;
						if (rx_bits == 4'(len - 4'h1)) begin
							rx_bits  <= 4'h0;
							rx_state <= par_en ? srl_pkg::RX_PARITY
							                   : srl_pkg::RX_STOP;
						end else begin
							rx_bits <= rx_bits + 4'h1;
						end
					end
				end
				srl_pkg::RX_PARITY: begin
					if (rx_samp) begin
						rx_par   <= rx_s;
						rx_state <= srl_pkg::RX_STOP;
					end
				end
				srl_pkg::RX_STOP: begin
					if (rx_samp) begin
						if (ctrl[srl_pkg::CTRL_STOP2] && rx_bits == 4'h0) begin
							rx_bits   <= 4'h1;
							frame_bad <= !rx_s;
						end else begin
							rx_state <= srl_pkg::RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Receive buffer, flags and requests
	assign ovr_set = deliver && rx_full && !rd_rx;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxbuf      <= 9'h000;
			rx_full    <= 1'b0;
			overrun    <= 1'b0;
			framing    <= 1'b0;
			parity_err <= 1'b0;
			rx_irq     <= 1'b0;
			tx_irq     <= 1'b0;
		end else begin
			if (deliver) begin
				rxbuf <= rx_shift & mask;
			end
			rx_full    <= deliver || (rx_full && !rd_rx);
			overrun    <= ovr_set || (overrun &&
			              !(wr_stat && wdata[srl_pkg::ST_OVERRUN]));
			framing    <= fe_now || (framing &&
			              !(wr_stat && wdata[srl_pkg::ST_FRAMING]));
			parity_err <= pe_now || (parity_err &&
			              !(wr_stat && wdata[srl_pkg::ST_PARITY]));
			rx_irq     <= deliver && !ovr_set;
			tx_irq     <= ctrl[srl_pkg::CTRL_TXIRQ_SEL] ? tx_done_ev
			                                            : tx_start;
		end
	end

	// ==========================================================
	// Register reads
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 16'h0000;
		end else if (!rd) begin
			rdata <= 16'h0000;
		end else begin
			unique case (addr)
				srl_pkg::ADDR_CTRL:  rdata <= ctrl;
				srl_pkg::ADDR_DIV:   rdata <= {8'h00, div};
				srl_pkg::ADDR_TXBUF: rdata <= {7'h00, txbuf};
				srl_pkg::ADDR_RXBUF: rdata <= {7'h00,
					ctrl[srl_pkg::CTRL_INVERT] ? ~rxbuf : rxbuf};
				srl_pkg::ADDR_STAT:  rdata <= {9'h000,
					overrun | framing | parity_err,
					parity_err, framing, overrun, rx_full,
					tx_state == srl_pkg::TX_IDLE, tx_empty};
				default:             rdata <= 16'h0000;
			endcase
		end
	end
endmodule

// File: srl_checker.sv
`timescale 1ns/1ps
module srl_checker (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        serial_in_pin,
	input wire logic        serial_out_pin,
	input wire logic        serial_out_oe,
	input wire logic        transfer_clock_pin_in,
	input wire logic        transfer_clock_pin_out,
	input wire logic        transfer_clock_pin_oe,
	input wire logic        tx_irq,
	input wire logic        rx_irq
);
	logic [15:0] ctrl;
	logic [7:0]  div;
	logic [7:0]  low_run;
	logic        fast;
	logic        asy;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Shadow of control and divider
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= srl_pkg::CTRL_RESET;
			div  <= srl_pkg::DIV_RESET;
		end else if (wr && addr == srl_pkg::ADDR_CTRL) begin
			ctrl <= wdata;
		end else if (wr && addr == srl_pkg::ADDR_DIV) begin
			div <= wdata[7:0];
		end
	end

	// Length of the current low run on the output
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			low_run <= 8'h00;
		end else if (serial_out_pin || low_run != 8'hff) begin
			low_run <= serial_out_pin ? 8'h00 : low_run + 8'h01;
		end
	end

	assign asy  = ctrl[srl_pkg::CTRL_ASYNC];
	assign fast = ctrl[14:13] == srl_pkg::SRC_F1 && !ctrl[3] && div == 8'h00;

	// ==========================================================
	// Properties
	property p_od_float;
		!serial_out_oe |-> serial_out_pin;
	endproperty
	a_od_float: assert property (p_od_float)
		else $error("output floats while low");

	property p_bit_len;
		$rose(serial_out_pin) && asy && fast |-> low_run[3:0] == 4'h0;
	endproperty
	a_bit_len: assert property (p_bit_len)
		else $error("low run not whole bits");

	property p_sclk_low;
		$fell(transfer_clock_pin_out) && transfer_clock_pin_oe && fast
			|-> !transfer_clock_pin_out [*8] ##1 transfer_clock_pin_out;
	endproperty
	a_sclk_low: assert property (p_sclk_low)
		else $error("shift clock low phase wrong");

	property p_err_sum;
		$past(rd) && $past(addr) == srl_pkg::ADDR_STAT
			|-> rdata[srl_pkg::ST_ERR_SUM] == |rdata[5:3];
	endproperty
	a_err_sum: assert property (p_err_sum)
		else $error("error sum mismatch");

	property p_tx_req_load;
		tx_irq && asy && !ctrl[srl_pkg::CTRL_TXIRQ_SEL]
			|-> ##[0:2] !serial_out_pin;
	endproperty
	a_tx_req_load: assert property (p_tx_req_load)
		else $error("transmit request not at frame start");

	property p_tx_req_end;
		tx_irq && asy && ctrl[srl_pkg::CTRL_TXIRQ_SEL] |-> serial_out_pin;
	endproperty
	a_tx_req_end: assert property (p_tx_req_end)
		else $error("transmit request before frame end");

	property p_rx_en;
		rx_irq |-> ctrl[srl_pkg::CTRL_RX_EN];
	endproperty
	a_rx_en: assert property (p_rx_en)
		else $error("receive request while disabled");

	property p_tx_en;
		$fell(serial_out_pin) && asy |-> ctrl[srl_pkg::CTRL_TX_EN];
	endproperty
	a_tx_en: assert property (p_tx_en)
		else $error("frame started while disabled");
endmodule

bind srl_uart srl_checker i_srl_checker (
	.clk                    (clk),
	.nrst                   (nrst),
	.addr                   (addr),
	.wdata                  (wdata),
	.wr                     (wr),
	.rd                     (rd),
	.rdata                  (rdata),
	.serial_in_pin          (serial_in_pin),
	.serial_out_pin         (serial_out_pin),
	.serial_out_oe          (serial_out_oe),
	.transfer_clock_pin_in  (transfer_clock_pin_in),
	.transfer_clock_pin_out (transfer_clock_pin_out),
	.transfer_clock_pin_oe  (transfer_clock_pin_oe),
	.tx_irq                 (tx_irq),
	.rx_irq                 (rx_irq)
);

// File: srl_peer.sv
`timescale 1ns/1ps
module srl_peer (
	input  wire logic clk,
	input  wire logic line_in,
	input  wire logic sclk,
	output logic      line_out
);
	int bit_cyc = 16;

	initial line_out = 1'b1;

	// ==========================================================
	// Sends a frame given start bit first
	task automatic send(input logic [12:0] f, input int n);
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			line_out <= f[i];
			repeat (bit_cyc) @(posedge clk);
		end
		line_out <= 1'b1;
	endtask

	// Samples a frame mid-bit after the falling start edge
	task automatic recv(output logic [12:0] f, input int n);
		int t;
		f = 'x;
		t = 0;
		while (line_in !== 1'b0 && t < 20 * bit_cyc) begin
			@(negedge clk);
			t++;
		end
		if (t < 20 * bit_cyc) begin
			f = '0;
			repeat (bit_cyc / 2) @(negedge clk);
			for (int i = 0; i < n; i++) begin
				f[i] = line_in;
				repeat (bit_cyc) @(negedge clk);
			end
		end
	endtask

	// Samples eight bits on rising shift clock
	task automatic srecv(output logic [7:0] b);
		logic prev;
		int   i;
		int   t;
		b = 'x;
		prev = 1'b1;
		i = 0;
		t = 0;
		while (i < 8 && t < 4000) begin
			@(negedge clk);
			t++;
			if (sclk && !prev) begin
				b[i] = line_in;
				i++;
			end
			prev = sclk;
		end
	endtask
endmodule

// File: srl_uart_tb.sv
`timescale 1ns/1ps
module srl_uart_tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ext_clk = 1'b0;
	logic [15:0] rdata;
	logic        sin;
	logic        sout;
	logic        sout_oe;
	logic        sclk;
	logic        tx_irq;
	logic        rx_irq;
	wire         line = sout_oe ? sout : 1'b1;
	int          err_total = 0;
	int          n_tests = 0;
	int          seed = 94213;

	always #5 clk = ~clk;
	always begin
		repeat (3) @(posedge clk);
		ext_clk <= ~ext_clk;
	end

	srl_uart i_srl_uart (
		.clk                    (clk),
		.nrst                   (nrst),
		.addr                   (addr),
		.wdata                  (wdata),
		.wr                     (wr),
		.rd                     (rd),
		.rdata                  (rdata),
		.serial_in_pin          (sin),
		.serial_out_pin         (sout),
		.serial_out_oe          (sout_oe),
		.transfer_clock_pin_in  (ext_clk),
		.transfer_clock_pin_out (sclk),
		.transfer_clock_pin_oe  (),
		.tx_irq                 (tx_irq),
		.rx_irq                 (rx_irq)
	);

	srl_peer i_srl_peer (
		.clk      (clk),
		.line_in  (line),
		.sclk     (sclk),
		.line_out (sin)
	);

	// ==========================================================
	// Checking and bus tasks
	task final_report;
		$display("errors %0d comparisons %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Waits for rx (0), tx (1) or either (2) request
	task automatic wait_evt(input int w, input int lim, input bit must,
	                        output bit got);
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			@(posedge clk);
			#1;
			got = (w != 1 && rx_irq === 1'b1) || (w != 0 && tx_irq === 1'b1);
		end
		if (must && !got) begin
			check(16'(got), 16'h0001);
			final_report;
		end
	endtask

	// Expected line bits of one frame, start bit first
	function automatic logic [12:0] frame(input logic [8:0] d,
	                                      input logic [15:0] c, output int n);
		int         nd;
		logic [12:0] f;
		logic       p;
		logic       b;
		nd = c[9:8] == srl_pkg::LEN_7 ? 7 : c[9:8] == srl_pkg::LEN_8 ? 8 : 9;
		f = 13'h0000;
		n = 1;
		p = c[srl_pkg::CTRL_PAR_ODD];
		for (int i = 0; i < nd; i++) begin
			b = c[srl_pkg::CTRL_MSB_FIRST] ? d[nd - 1 - i] : d[i];
			f[n] = b;
			p ^= b;
			n++;
		end
		if (c[srl_pkg::CTRL_PAR_EN]) begin
			f[n] = p;
			n++;
		end
		f[n] = 1'b1;
		n = n + (c[srl_pkg::CTRL_STOP2] ? 2 : 1);
		f[n - 1] = 1'b1;
		return f;
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		logic [15:0] c;
		logic [15:0] r;
		logic [12:0] f;
		logic [12:0] fs;
		logic [8:0]  d;
		logic [8:0]  m;
		logic [7:0]  b8;
		int          n;
		int          bc;
		bit          got;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rreg(srl_pkg::ADDR_CTRL, r);
		check(r, 16'h0000);
		rreg(srl_pkg::ADDR_STAT, r);
		check(r, 16'h0003);
		check(16'(sout), 16'h0001);
		wreg(srl_pkg::ADDR_DIV, 16'hffff);
		rreg(srl_pkg::ADDR_DIV, r);
		check(r, 16'h00ff);
		rreg(4'hf, r);
		check(r, 16'h0000);
		for (int k = 0; k < 12; k++) begin
			c = 16'h0007 | (16'($random(seed)) & 16'h9fd0);
			if (k == 0) c = c | 16'h0e00;
			if (k == 1) c = c & 16'hf0ff;
			c[14:13] = k % 4 == 2 ? {k == 6, k != 6} : srl_pkg::SRC_F1;
			c[3] = k % 4 == 3;
			bc = k % 4 == 1 ? 48 : k % 4 == 2 ? 128 : k % 4 == 3 ? 96 : 16;
			if (k == 6) bc = 512;
			i_srl_peer.bit_cyc = bc;
			m = c[9:8] == 2'h0 ? 9'h07f : c[9:8] == 2'h1 ? 9'h0ff : 9'h1ff;
			wreg(srl_pkg::ADDR_CTRL, c);
			wreg(srl_pkg::ADDR_DIV, k % 4 == 1 ? 16'h0002 : 16'h0000);
			d = 9'($random(seed));
			f = frame(c[6] ? ~d : d, c, n);
			fork
				i_srl_peer.recv(fs, n);
				begin
					wreg(srl_pkg::ADDR_TXBUF, {7'h00, d});
					wait_evt(1, 15 * bc, 1'b1, got);
				end
			join
			check(16'(fs), 16'(f));
			d = 9'($random(seed));
			fork
				i_srl_peer.send(frame(d, c, n), n);
				wait_evt(0, 15 * bc, 1'b1, got);
			join
			rreg(srl_pkg::ADDR_RXBUF, r);
			check({7'h00, r[8:0] & m}, {7'h00, (c[6] ? ~d : d) & m});
			rreg(srl_pkg::ADDR_STAT, r);
			check(r & 16'h0078, 16'h0000);
		end
		// Parity, framing and overrun errors
		c = 16'h0907;
		i_srl_peer.bit_cyc = 16;
		wreg(srl_pkg::ADDR_CTRL, c);
		for (int e = 0; e < 3; e++) begin
			d = 9'($random(seed));
			if (e == 2) begin
				fork
					i_srl_peer.send(frame(d, c, n), n);
					wait_evt(0, 300, 1'b1, got);
				join
				d = 9'($random(seed));
			end
			f = frame(d, c, n);
			f = f ^ (e == 0 ? 13'h0200 : e == 1 ? 13'h0400 : 13'h0000);
			fork
				i_srl_peer.send(f, n);
				wait_evt(0, 300, e != 2, got);
			join
			if (e == 2) check(16'(got), 16'h0000);
			rreg(srl_pkg::ADDR_RXBUF, r);
			check(r & 16'h00ff, {8'h00, d[7:0]});
			rreg(srl_pkg::ADDR_STAT, r);
			check(r & 16'h0078, e == 0 ? 16'h0060 : e == 1 ? 16'h0050
			      : 16'h0048);
			wreg(srl_pkg::ADDR_STAT, 16'h0038);
		end
		// Disabled transmitter and receiver stay quiet
		wreg(srl_pkg::ADDR_CTRL, 16'h0104);
		wreg(srl_pkg::ADDR_TXBUF, 16'h00a5);
		fork
			i_srl_peer.send(frame(9'h05a, 16'h0104, n), n);
			wait_evt(2, 250, 1'b0, got);
		join
		check(16'(got), 16'h0000);
		// Synchronous mode: held data leaves MSB first
		c = 16'h0183;
		fork
			i_srl_peer.srecv(b8);
			begin
				wreg(srl_pkg::ADDR_CTRL, c);
				wait_evt(0, 400, 1'b1, got);
			end
		join
		f = frame(9'h0a5, c, n);
		check(16'(b8), 16'(f[8:1]));
		rreg(srl_pkg::ADDR_RXBUF, r);
		check(r & 16'h00ff, 16'h00ff);
		wreg(srl_pkg::ADDR_CTRL, 16'h01a2);
		rreg(srl_pkg::ADDR_RXBUF, r);
		wait_evt(0, 400, 1'b1, got);
		rreg(srl_pkg::ADDR_RXBUF, r);
		check(r & 16'h00ff, 16'h00ff);
		final_report;
	end
endmodule
